// ---- src/gk_pkg.sv ----
/*
 * Shared constants for the pin control block: register offsets, field
 * positions, reset values and debounce timing.
 * Assumes a 16-bit plain register port with byte-addressed even offsets.
 */
package gk_pkg;
   // Register offsets on the plain register port.
   localparam logic [4:0] GK_OFS_DATA   = 5'h00; // Output data high byte, pin level low byte.
   localparam logic [4:0] GK_OFS_IOEN   = 5'h02; // Input enables high byte, output enables low byte.
   localparam logic [4:0] GK_OFS_PULL   = 5'h04; // Pull-up select high byte, pull enables low byte.
   localparam logic [4:0] GK_OFS_FLAGS  = 5'h06; // Edge event flags, write one to clear.
   localparam logic [4:0] GK_OFS_IRQCTL = 5'h08; // Edge select high byte, event enables low byte.
   localparam logic [4:0] GK_OFS_DEBEN  = 5'h0a; // Debounce enables.
   localparam logic [4:0] GK_OFS_MODSEL = 5'h0c; // Peripheral function select.
   localparam logic [4:0] GK_OFS_FNC    = 5'h0e; // Two-bit peripheral choice per pin.
   localparam logic [4:0] GK_OFS_CLKCFG = 5'h10; // Debug run and key reset combination.
   // Field positions.
   localparam int GK_HI_LSB       = 8;
   localparam int GK_DBGRUN_BIT   = 0;
   localparam int GK_KEYCMB_LSB   = 1;
   // Reset values.
   localparam logic [15:0] GK_RST_ZERO = 16'h0000;
   // Debounce: stable samples of the port function clock before the output moves.
   localparam int GK_DB_SAMPLES   = 2;
   // Key reset combination codes.
   typedef enum logic [1:0] {
      GK_KEY_OFF = 2'b00,
      GK_KEY_P01 = 2'b01,
      GK_KEY_P02 = 2'b10,
      GK_KEY_P03 = 2'b11
   } gk_key_e;
endpackage

// ---- src/gk_debounce.sv ----
/*
 * One pin's debounce filter, stepped by the port function clock tick.
 * Assumes din is already synchronised to clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
module gk_debounce
   import gk_pkg::*;
#(
   parameter int SAMPLES = gk_pkg::GK_DB_SAMPLES
) (
   // Clock and reset.
   input  wire logic clk_sys,
   input  wire logic arst_n,
   // Control.
   input  wire logic tick,
   input  wire logic en,
   input  wire logic bypass,
   // Level in and out.
   input  wire logic din,
   output logic      dout
);
   logic [SAMPLES-1:0] hist_reg; // Last samples taken on ticks.
   logic               filt_reg; // Accepted level.

   // Shift a sample in on every delivered tick; a level is accepted only when
   // it matches every stored sample, so pulses under two to three periods die.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         hist_reg <= '0;
         filt_reg <= 1'b0;
      end else if (!en) begin
         // Track the pin so that enabling the filter starts from the live level.
         hist_reg <= {SAMPLES{din}};
         filt_reg <= din;
      end else if (tick) begin
         hist_reg <= {hist_reg[SAMPLES-2:0], din};
         if (hist_reg == {SAMPLES{din}}) begin // [RL24] [RL14]
            filt_reg <= din;
         end
      end
   end

   // Bypass passes the pin straight through while the clock is stopped in sleep.
   assign dout = (en && !bypass) ? filt_reg : din; // [RL13] [RL16]
endmodule
`default_nettype wire

// ---- src/gk_port.sv ----
/*
 * Pin control block: GPIO enables, pulls, peripheral hand-over, per-pin
 * debounce, edge events and the key-entry reset detector.
 * Assumes a plain single-cycle register port on clk_sys, a port function
 * clock given as a one-cycle tick from the clock generator, and pad logic
 * outside that resolves pin_out, pin_oe and the pull requests.
 */
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RL1: Debug without debug run withholds the port clock.
// RL2: Withheld clock freezes filter; registers stay writable.
// RL3: Debug run keeps the port clock in debug.
// RL4: Reset: GPIO, disabled, no pulls, debug pins debug.
// RL5: Software hands pins to peripherals in order.
// RL6: Selected peripheral fully owns the pin.
// RL7: Software sets output then clears function select.
// RL8: Software follows the input setup order.
// RL9: Pull only with output off and pull enabled.
// RL10: Pins without GPIO read zero, stay reset.
// RL11: Enabled output drives the out value.
// RL12: Pin value shows the sampled pin level.
// RL13: Each pin has its own debounce enable.
// RL14: Filter rejects pulses under two-three clock periods.
// RL15: Software waits four port clocks before enabling events.
// RL16: Clock stopped in sleep bypasses the filter.
// RL17: All chosen pins low raises reset request.
// RL18: Software makes key pins inputs before choosing.
// RL19: Key reset follows filter or raw level.
// RL20: Key pins still work as GPIO inputs.
// RL21: Disabled input reads pin value zero.
// RL22: Edge select one falling, zero rising.
// RL23: Flag sets on edge, cleared by writing one.
// RL24: Filter moves after stable consecutive samples.
module gk_port
   import gk_pkg::*;
#(
   parameter int          NPINS    = 8,
   parameter logic [7:0]  GPIO_MSK = 8'hff, // Pins that have a GPIO function.
   parameter logic [7:0]  DBG_MSK  = 8'h00  // Pins that carry debug signals after reset.
) (
   // Clock and reset.
   input  wire logic              clk_sys,
   input  wire logic              arst_n,
   // Register port.
   input  wire logic [4:0]        reg_addr,
   input  wire logic [15:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [15:0]            reg_rdata,
   // Port function clock and power modes.
   input  wire logic              pfc_tick,
   input  wire logic              cpu_debug,
   input  wire logic              sleep_mode,
   input  wire logic              sleep_clk_stop,
   // Pins.
   input  wire logic [NPINS-1:0]  pin_in,
   output logic [NPINS-1:0]       pin_out,
   output logic [NPINS-1:0]       pin_oe,
   output logic [NPINS-1:0]       pull_up_en,
   output logic [NPINS-1:0]       pull_dn_en,
   // Peripheral side.
   input  wire logic [NPINS-1:0]  periph_out,
   input  wire logic [NPINS-1:0]  periph_oe,
   output logic [NPINS-1:0]       periph_in,
   output logic [2*NPINS-1:0]     periph_func_choice,
   // Requests.
   output logic                   irq_req,
   output logic                   key_rst_req
);
   localparam logic [NPINS-1:0] GMSK = GPIO_MSK[NPINS-1:0];
   localparam logic [NPINS-1:0] DMSK = DBG_MSK[NPINS-1:0];

   // Control registers.
   logic [NPINS-1:0]   out_value_reg;      // Output data.
   logic [NPINS-1:0]   input_enable_reg;   // Input enables.
   logic [NPINS-1:0]   output_enable_reg;  // Output enables.
   logic [NPINS-1:0]   pull_enable_reg;    // Pull enables.
   logic [NPINS-1:0]   pull_up_select_reg; // One selects pull-up.
   logic [NPINS-1:0]   irq_flag_reg;       // Sticky edge flags.
   logic [NPINS-1:0]   irq_enable_reg;     // Event enables.
   logic [NPINS-1:0]   irq_edge_reg;       // One selects falling edge.
   logic [NPINS-1:0]   debounce_en_reg;    // Per-pin filter enables.
   logic [NPINS-1:0]   periph_sel_reg;     // One hands the pin to a peripheral.
   logic [2*NPINS-1:0] func_choice_reg;    // Peripheral choice.
   logic               debug_run_reg;      // Keep port clock in debug.
   logic [1:0]         key_combo_reg;      // Key reset combination.
   // Input path.
   logic [NPINS-1:0]   sync1_reg;          // First synchroniser stage.
   logic [NPINS-1:0]   sync2_reg;          // Second synchroniser stage.
   logic [NPINS-1:0]   filt;               // Filtered or bypassed levels.
   logic [NPINS-1:0]   gated_in;           // Level seen by GPIO input logic.
   logic [NPINS-1:0]   prev_in_reg;        // Previous gated level.
   logic [NPINS-1:0]   edge_ev;            // Selected edge this cycle.
   logic [NPINS-1:0]   flag_clr;           // Write-one-to-clear mask.
   logic               dbg_halt;           // Port clock withheld for debug.
   logic               sleep_byp;          // Port clock stopped in sleep.
   logic               pfc_live;           // Delivered port clock tick.
   logic               wr_hit;             // Helper for write decode.

   // Widen a pin vector into an 8-bit register lane.
   function automatic logic [7:0] lane(input logic [NPINS-1:0] v);
      lane = 8'h00;
      lane[NPINS-1:0] = v;
   endfunction

   // Pins chosen by the key reset combination; code one uses pins 0 and 1.
   function automatic logic [NPINS-1:0] key_pins(input logic [1:0] c);
      key_pins = '0;
      case (gk_key_e'(c))
         GK_KEY_OFF: key_pins = '0;
         GK_KEY_P01: key_pins[1:0] = 2'b11;
         GK_KEY_P02: key_pins[2:0] = 3'b111;
         GK_KEY_P03: key_pins[3:0] = 4'b1111;
         default:    key_pins = '0;
      endcase
   endfunction

   // Port clock delivery: debug halts it unless debug run is set, and a
   // clock that stops in sleep turns the filter into a wire instead.
   assign dbg_halt  = cpu_debug && !debug_run_reg;   // [RL1] [RL3]
   assign sleep_byp = sleep_mode && sleep_clk_stop;
   assign pfc_live  = pfc_tick && !dbg_halt && !sleep_byp;
   assign wr_hit    = reg_wr;

   // Pins are asynchronous to clk_sys, so two flops precede any logic.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
      end
   end

   // One filter per pin; a pin without a debounce enable sees the raw level.
   for (genvar i = 0; i < NPINS; i++) begin : g_db
      gk_debounce #(.SAMPLES(GK_DB_SAMPLES)) u_db (
         .clk_sys (clk_sys),
         .arst_n  (arst_n),
         .tick    (pfc_live),            // [RL2]
         .en      (debounce_en_reg[i]),  // [RL13]
         .bypass  (sleep_byp),           // [RL16]
         .din     (sync2_reg[i]),
         .dout    (filt[i])
      );
   end

   // GPIO input is live only with input enabled and the GPIO function chosen.
   assign gated_in  = filt & input_enable_reg & ~periph_sel_reg & GMSK; // [RL12] [RL21]
   assign periph_in = sync2_reg;

   // Edge select one picks falling edges, zero picks rising edges.
   assign edge_ev = (irq_edge_reg & prev_in_reg & ~gated_in) |
                    (~irq_edge_reg & ~prev_in_reg & gated_in); // [RL22]
   assign flag_clr = (wr_hit && reg_addr == GK_OFS_FLAGS) ? reg_wdata[NPINS-1:0] : '0;

   // Previous gated level for edge detection.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         prev_in_reg <= '0;
      end else begin
         prev_in_reg <= gated_in;
      end
   end

   // Sticky flags: an edge in the clearing cycle wins over the clear.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         irq_flag_reg <= '0;
      end else begin
         irq_flag_reg <= ((irq_flag_reg & ~flag_clr) | edge_ev) & GMSK; // [RL23]
      end
   end

   // GPIO control registers; bits of pins without GPIO stay zero.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         out_value_reg      <= '0; // [RL4]
         input_enable_reg   <= '0;
         output_enable_reg  <= '0;
         pull_enable_reg    <= '0;
         pull_up_select_reg <= '0;
         irq_enable_reg     <= '0;
         irq_edge_reg       <= '0;
         debounce_en_reg    <= '0;
      end else if (wr_hit) begin
         // Writes are taken even while the port clock is withheld.
         case (reg_addr)
            GK_OFS_DATA: begin
               out_value_reg <= reg_wdata[GK_HI_LSB +: NPINS] & GMSK; // [RL10] [RL2]
            end
            GK_OFS_IOEN: begin
               input_enable_reg  <= reg_wdata[GK_HI_LSB +: NPINS] & GMSK;
               output_enable_reg <= reg_wdata[NPINS-1:0] & GMSK;
            end
            GK_OFS_PULL: begin
               pull_up_select_reg <= reg_wdata[GK_HI_LSB +: NPINS] & GMSK;
               pull_enable_reg    <= reg_wdata[NPINS-1:0] & GMSK;
            end
            GK_OFS_IRQCTL: begin
               irq_edge_reg   <= reg_wdata[GK_HI_LSB +: NPINS] & GMSK;
               irq_enable_reg <= reg_wdata[NPINS-1:0] & GMSK;
            end
            GK_OFS_DEBEN: begin
               debounce_en_reg <= reg_wdata[NPINS-1:0] & GMSK;
            end
            default: begin
               // Other offsets hold no GPIO control bits.
            end
         endcase
      end
   end

   // Function select and clock configuration; debug pins start handed to
   // the debug function so that a debugger can attach straight after reset.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         periph_sel_reg  <= DMSK; // [RL4]
         func_choice_reg <= '0;
         debug_run_reg   <= 1'b0;
         key_combo_reg   <= GK_KEY_OFF;
      end else if (wr_hit) begin
         case (reg_addr)
            GK_OFS_MODSEL: periph_sel_reg <= reg_wdata[NPINS-1:0];
            GK_OFS_FNC:    func_choice_reg <= reg_wdata[2*NPINS-1:0];
            GK_OFS_CLKCFG: begin
               debug_run_reg <= reg_wdata[GK_DBGRUN_BIT];
               key_combo_reg <= reg_wdata[GK_KEYCMB_LSB +: 2];
            end
            default: begin
               // Nothing else lives in this process.
            end
         endcase
      end
   end

   // Read data stand in the cycle after the read strobe; unmapped reads zero.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= GK_RST_ZERO;
      end else if (reg_rd) begin
         case (reg_addr)
            GK_OFS_DATA:   reg_rdata <= {lane(out_value_reg), lane(gated_in)}; // [RL12] [RL20]
            GK_OFS_IOEN:   reg_rdata <= {lane(input_enable_reg), lane(output_enable_reg)};
            GK_OFS_PULL:   reg_rdata <= {lane(pull_up_select_reg), lane(pull_enable_reg)};
            GK_OFS_FLAGS:  reg_rdata <= {8'h00, lane(irq_flag_reg)};
            GK_OFS_IRQCTL: reg_rdata <= {lane(irq_edge_reg), lane(irq_enable_reg)};
            GK_OFS_DEBEN:  reg_rdata <= {8'h00, lane(debounce_en_reg)};
            GK_OFS_MODSEL: reg_rdata <= {8'h00, lane(periph_sel_reg)};
            GK_OFS_FNC:    reg_rdata <= 16'(func_choice_reg);
            GK_OFS_CLKCFG: reg_rdata <= {13'h0000, key_combo_reg, debug_run_reg};
            default:       reg_rdata <= GK_RST_ZERO;
         endcase
      end else begin
         reg_rdata <= GK_RST_ZERO;
      end
   end

   // Pad control: a selected peripheral owns drive and enable, GPIO settings
   // then do nothing; pulls act only with output off and pull enabled.
   assign pin_out    = (periph_sel_reg & periph_out) | (~periph_sel_reg & out_value_reg); // [RL6] [RL11]
   assign pin_oe     = (periph_sel_reg & periph_oe) | (~periph_sel_reg & output_enable_reg);
   assign pull_up_en = ~periph_sel_reg & ~output_enable_reg & pull_enable_reg & pull_up_select_reg; // [RL9]
   assign pull_dn_en = ~periph_sel_reg & ~output_enable_reg & pull_enable_reg & ~pull_up_select_reg;
   assign periph_func_choice = func_choice_reg;

   // Event request to the interrupt controller and the key reset request.
   // The key detector reads the filtered level, so it is immediate with the
   // filter off and needs a long low with the filter on; it does not depend
   // on input enable, so key pins behave as ordinary inputs meanwhile.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         irq_req     <= 1'b0;
         key_rst_req <= 1'b0;
      end else begin
         irq_req     <= |(irq_flag_reg & irq_enable_reg);
         key_rst_req <= (key_combo_reg != GK_KEY_OFF) &&
                        ((filt & key_pins(key_combo_reg)) == '0); // [RL17] [RL19] [RL20]
      end
   end

   // Checks on the behaviour above.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   sequence s_keys_low;
      (key_combo_reg != GK_KEY_OFF) && ((filt & key_pins(key_combo_reg)) == '0);
   endsequence

   a_key_reset_req: assert property (s_keys_low |=> key_rst_req) // [RL17]
      else $error("key reset request missing");
   a_pull_off_out: assert property (((pull_up_en | pull_dn_en) & output_enable_reg) == '0) // [RL9]
      else $error("pull active with output enabled");
   a_periph_owns_pin: assert property (((pin_oe ^ periph_oe) & periph_sel_reg) == '0) // [RL6]
      else $error("peripheral does not own pin enable");
   a_gpio_out_drive: assert property (((pin_out ^ out_value_reg) & output_enable_reg & ~periph_sel_reg) == '0) // [RL11]
      else $error("gpio output level wrong");
   a_read_zero_off: assert property (reg_rd && reg_addr == GK_OFS_DATA |=>
                                     (reg_rdata[NPINS-1:0] & ~$past(input_enable_reg)) == '0) // [RL21]
      else $error("disabled input read nonzero");
   a_flag_zero_hold: assert property ((irq_flag_reg & ~$past(irq_flag_reg) & ~$past(edge_ev)) == '0) // [RL23]
      else $error("flag set without edge");
   a_edge_sets_flag: assert property ((edge_ev != '0) |=> (irq_flag_reg & $past(edge_ev)) == $past(edge_ev)) // [RL22]
      else $error("edge did not set flag");
   a_dbg_freeze: assert property (dbg_halt && !sleep_byp && $past(dbg_halt) && $stable(debounce_en_reg)
                                  |-> $stable(filt & debounce_en_reg)) // [RL2]
      else $error("filter moved while clock withheld");
   a_sleep_bypass: assert property (sleep_byp |-> filt == sync2_reg) // [RL16]
      else $error("filter not bypassed in sleep");
   a_no_gpio_zero: assert property (((input_enable_reg | output_enable_reg | out_value_reg) & ~GMSK) == '0) // [RL10]
      else $error("gpio bits set on non-gpio pin");
endmodule
`default_nettype wire

// ---- verification/gk_pin_model.sv ----
/* Pad and switch model for the port pins.
   Assumes the pad requests of the pin control block on one clock. */
`timescale 1ns/1ps
`default_nettype none
module gk_pin_model #(
   parameter int NPINS = 8
) (
   // Clock.
   input  wire logic             clk_sys,
   // Pad requests from the block.
   input  wire logic [NPINS-1:0] pin_out,
   input  wire logic [NPINS-1:0] pin_oe,
   input  wire logic [NPINS-1:0] pull_up_en,
   input  wire logic [NPINS-1:0] pull_dn_en,
   // External switches.
   input  wire logic [NPINS-1:0] sw_drive,
   input  wire logic [NPINS-1:0] sw_level,
   // Resolved pin level.
   output logic      [NPINS-1:0] pin_wire
);
   logic [NPINS-1:0] float_pat = '0; // Stand-in level of a floating pad.
   // A floating pad toggles every cycle, so a settled unknown never hides a fault.
   always_ff @(posedge clk_sys) begin
      float_pat <= ~float_pat;
   end
   // The block's drive wins, then a closed switch, then a pull.
   always_comb begin
      for (int i = 0; i < NPINS; i++) begin
         if (pin_oe[i]) begin
            pin_wire[i] = pin_out[i];
         end else if (sw_drive[i]) begin
            pin_wire[i] = sw_level[i];
         end else if (pull_up_en[i] | pull_dn_en[i]) begin
            pin_wire[i] = pull_up_en[i];
         end else begin
            pin_wire[i] = float_pat[i];
         end
      end
   end
endmodule
`default_nettype wire

// ---- verification/gpio_pin_control_debounce_keyreset_tb_top.sv ----
/* Self-checking bench for the pin control block.
   Assumes gk_pkg and the pad model gk_pin_model. */
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_control_debounce_keyreset_tb_top;
   import gk_pkg::*;
   // Stimulus and observed signals.
   logic        clk_sys, arst_n, reg_wr, reg_rd, pfc_tick, tick_run;
   logic        cpu_debug, sleep_mode, sleep_clk_stop, irq_req, key_rst_req;
   logic [4:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, periph_func_choice;
   logic [7:0]  pin_in, pin_out, pin_oe, pull_up_en, pull_dn_en, m;
   logic [7:0]  periph_out, periph_oe, periph_in, sw_drive, sw_level;
   logic [1:0]  tick_cnt;
   int          n_errors, checks;
   // One row: enables, pulls, data and the pad requests they should give.
   typedef struct packed {
      logic [15:0] ioen, pull, data;
      logic [7:0]  oe, pu, pd, dout;
   } gk_row_s;
   gk_row_s rows [5] = '{
      '{16'h0000, 16'h00ff, 16'h0000, 8'h00, 8'h00, 8'hff, 8'h00},
      '{16'h0000, 16'hff0f, 16'h0000, 8'h00, 8'h0f, 8'h00, 8'h00},
      '{16'h000f, 16'hffff, 16'ha500, 8'h0f, 8'hf0, 8'h00, 8'h05},
      '{16'hff00, 16'hf0f0, 16'h0000, 8'h00, 8'hf0, 8'h00, 8'h00},
      '{16'h00ff, 16'hf0ff, 16'h3c00, 8'hff, 8'h00, 8'h00, 8'h3c}};
   gk_port gk_port_inst (
      .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pfc_tick(pfc_tick), .cpu_debug(cpu_debug),
      .sleep_mode(sleep_mode), .sleep_clk_stop(sleep_clk_stop), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en), .periph_out(periph_out),
      .periph_oe(periph_oe), .periph_in(periph_in), .periph_func_choice(periph_func_choice),
      .irq_req(irq_req), .key_rst_req(key_rst_req));
   gk_pin_model gk_pin_model_inst (
      .clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
      .pull_dn_en(pull_dn_en), .sw_drive(sw_drive), .sw_level(sw_level), .pin_wire(pin_in));
   // System clock at 100 MHz.
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Port clock tick on every fourth system cycle while running.
   always @(posedge clk_sys) begin
      tick_cnt <= tick_cnt + 2'h1;
      pfc_tick <= tick_run && (tick_cnt == 2'h3);
   end
   // Compare and count; a mismatch is reported at once.
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Settle one microsecond-free step past the edge so samples never race.
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // One-cycle write strobe.
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   // One-cycle read strobe; data stand only in the following cycle.
   task automatic rdc(input string what, input logic [4:0] a, input logic [15:0] exp);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk(what, reg_rdata, exp);
   endtask
   // Verdict and end of run.
   task automatic complete_run();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Bounded wait for the key reset request; a timeout ends the run.
   task automatic wait_key();
      int i;
      for (i = 0; i < 10 && key_rst_req !== 1'b1; i++) cyc(1);
      chk("key request", {15'h0, key_rst_req}, 16'h0001);
      if (key_rst_req !== 1'b1) complete_run();
   endtask
   initial begin
      {arst_n, reg_wr, reg_rd, pfc_tick, tick_run, cpu_debug, sleep_mode, sleep_clk_stop} = '0;
      {reg_addr, reg_wdata, periph_out, periph_oe, sw_drive, sw_level, tick_cnt} = '0;
      n_errors = 0;
      checks = 0;
      repeat (10) @(posedge clk_sys);
      arst_n <= 1'b1;
      cyc(1);
      // Reset state of pads, requests and every register, plus one unmapped place.
      chk("reset pads", {pin_oe, pull_up_en | pull_dn_en}, 16'h0000);
      chk("reset req", {14'h0, irq_req, key_rst_req}, 16'h0000);
      for (int a = 0; a <= 18; a += 2) rdc("reset reg", a[4:0], 16'h0000);
      // Table of enable and pull combinations, switches open so pulls decide.
      foreach (rows[i]) begin
         wr(GK_OFS_IOEN, rows[i].ioen);
         wr(GK_OFS_PULL, rows[i].pull);
         wr(GK_OFS_DATA, rows[i].data);
         cyc(1);
         chk("pin_oe", {8'h00, pin_oe}, {8'h00, rows[i].oe});
         chk("pulls", {pull_up_en, pull_dn_en}, {rows[i].pu, rows[i].pd});
         chk("pin_out", {8'h00, pin_out & pin_oe}, {8'h00, rows[i].dout});
         rdc("ioen reg", GK_OFS_IOEN, rows[i].ioen);
         rdc("pull reg", GK_OFS_PULL, rows[i].pull);
      end
      // Input reads follow the pin, and read zero once input is disabled.
      sw_drive <= 8'hff;
      sw_level <= 8'h5a;
      wr(GK_OFS_IOEN, 16'hff00);
      cyc(3);
      rdc("pin value", GK_OFS_DATA, 16'h3c5a);
      wr(GK_OFS_IOEN, 16'h0000);
      rdc("input off", GK_OFS_DATA, 16'h3c00);
      // Hand pin 0 to a peripheral; GPIO settings must lose control of it.
      wr(GK_OFS_MODSEL, 16'h0000);
      wr(GK_OFS_FNC, 16'h0002);
      wr(GK_OFS_MODSEL, 16'h0001);
      wr(GK_OFS_IOEN, 16'hff00);
      wr(GK_OFS_PULL, 16'h00ff);
      periph_oe <= 8'h01;
      periph_out <= 8'h01;
      cyc(3);
      chk("periph pads", {pin_oe, pin_out & pin_oe}, 16'h0101);
      chk("periph pulls", {pull_up_en, pull_dn_en}, 16'h00fe);
      chk("periph route", {periph_in, periph_func_choice[7:0]}, 16'h5b02);
      rdc("periph masked", GK_OFS_DATA, 16'h3c5a);
      wr(GK_OFS_MODSEL, 16'h0000);
      wr(GK_OFS_PULL, 16'h0000);
      periph_oe <= 8'h00;
      // Pin 1 flags on falling, pin 2 on rising; flags clear only by writing one.
      sw_level <= 8'hff;
      wr(GK_OFS_IRQCTL, 16'h0206);
      wr(GK_OFS_FLAGS, 16'h00ff);
      sw_level <= 8'hf9;
      cyc(5);
      rdc("fall flag", GK_OFS_FLAGS, 16'h0002);
      chk("irq req", {15'h0, irq_req}, 16'h0001);
      sw_level <= 8'hff;
      cyc(5);
      rdc("rise flag", GK_OFS_FLAGS, 16'h0006);
      wr(GK_OFS_FLAGS, 16'h0000);
      rdc("zero write", GK_OFS_FLAGS, 16'h0006);
      wr(GK_OFS_FLAGS, 16'h0002);
      rdc("one write", GK_OFS_FLAGS, 16'h0004);
      wr(GK_OFS_IRQCTL, 16'h0202);
      cyc(2);
      chk("irq masked", {15'h0, irq_req}, 16'h0000);
      // Debounce on pin 3 only: a short low is lost there but seen on pin 4.
      wr(GK_OFS_IRQCTL, 16'h0000);
      wr(GK_OFS_DEBEN, 16'h0008);
      tick_run <= 1'b1;
      cyc(20);
      wr(GK_OFS_FLAGS, 16'h00ff);
      wr(GK_OFS_IRQCTL, 16'h1818);
      sw_level <= 8'he7;
      cyc(6);
      sw_level <= 8'hff;
      cyc(20);
      rdc("short low", GK_OFS_FLAGS, 16'h0010);
      wr(GK_OFS_FLAGS, 16'h00ff);
      sw_level <= 8'he7;
      cyc(40);
      rdc("long low", GK_OFS_FLAGS, 16'h0018);
      sw_level <= 8'hff;
      cyc(40);
      wr(GK_OFS_FLAGS, 16'h00ff);
      // Debug without debug run freezes the filter; registers still take writes.
      cpu_debug <= 1'b1;
      sw_level <= 8'hf7;
      cyc(40);
      rdc("debug frozen", GK_OFS_FLAGS, 16'h0000);
      wr(GK_OFS_IRQCTL, 16'h1800);
      wr(GK_OFS_DEBEN, 16'h0018);
      rdc("debug write", GK_OFS_DEBEN, 16'h0018);
      wr(GK_OFS_CLKCFG, 16'h0001);
      cyc(40);
      rdc("debug run", GK_OFS_FLAGS, 16'h0008);
      cpu_debug <= 1'b0;
      sw_level <= 8'hff;
      cyc(40);
      wr(GK_OFS_FLAGS, 16'h00ff);
      // Sleep: a short low is filtered while the port clock runs, and passes straight through once it is stopped.
      sleep_mode <= 1'b1;
      sw_level <= 8'he7;
      cyc(3);
      sw_level <= 8'hff;
      cyc(20);
      rdc("sleep filter", GK_OFS_FLAGS, 16'h0000);
      tick_run <= 1'b0;
      sleep_clk_stop <= 1'b1;
      cyc(2);
      sw_level <= 8'he7;
      cyc(3);
      sw_level <= 8'hff;
      cyc(6);
      rdc("sleep bypass", GK_OFS_FLAGS, 16'h0018);
      {sleep_mode, sleep_clk_stop, tick_run} <= 3'b001;
      wr(GK_OFS_DEBEN, 16'h0000);
      wr(GK_OFS_IOEN, 16'hff00);
      // Every key combination: partial lows stay quiet, all lows request reset.
      for (int k = 1; k <= 3; k++) begin
         m = 8'((2 << k) - 1);
         wr(GK_OFS_CLKCFG, 16'(k << GK_KEYCMB_LSB));
         sw_level <= ~(m >> 1);
         cyc(4);
         chk("key partial", {15'h0, key_rst_req}, 16'h0000);
         sw_level <= ~m;
         wait_key();
         rdc("key pin data", GK_OFS_DATA, {8'h3c, ~m});
         sw_level <= 8'hff;
         cyc(4);
      end
      wr(GK_OFS_CLKCFG, 16'h0000);
      sw_level <= 8'h00;
      cyc(4);
      chk("key off", {15'h0, key_rst_req}, 16'h0000);
      complete_run();
   end
endmodule
`default_nettype wire
